// ===== include/wds_pkg.sv
package wds_pkg;

  // register byte addresses on the wishbone slave
  localparam logic [7:0] WDS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] WDS_ADDR_PIN_SETUP = 8'h04;
  localparam logic [7:0] WDS_ADDR_SETUP_WORD = 8'h08;
  localparam logic [7:0] WDS_ADDR_STATUS = 8'h0c;

  // reset values
  localparam logic [3:0] WDS_PERIOD_RST = 4'h4;
  localparam logic WDS_SOFT_EN_RST = 1'b0;
  localparam logic [7:0] WDS_PIN_SETUP_RST = 8'hff;
  localparam logic [7:0] WDS_SETUP_WORD_RST = 8'h00;

  // field positions
  localparam int WDS_CTRL_SOFT_EN_BIT = 0;
  localparam int WDS_CTRL_PERIOD_LSB = 1;
  localparam int WDS_CFG_FIXED_EN_BIT = 3;
  localparam int WDS_OPT_ASSIGN_BIT = 3;
  localparam int WDS_OPT_RATE_LSB = 0;

  // period codes above this one are reserved
  localparam logic [3:0] WDS_PERIOD_MAX = 4'hb;
  localparam logic [15:0] WDS_BASE_RATIO = 16'h0020;

  // low-frequency time base derived from the system clock
  localparam int unsigned WDS_CLK_HZ = 250_000_000;
  localparam int unsigned WDS_LF_OSC_HZ = 31_000;
  localparam int unsigned WDS_LF_TICK_CYC = WDS_CLK_HZ / WDS_LF_OSC_HZ;

  // interrupt vector taken after an interrupt wake-up with global enable set
  localparam logic [12:0] WDS_IRQ_VECTOR = 13'h0004;

  typedef enum logic [2:0] {
    WDS_AWAKE = 3'b001,
    WDS_SLEEP = 3'b010,
    WDS_WAKE = 3'b100
  } wds_mode_e;

  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wds_wb_req_s;

  // events and levels from the processor core and clock unit
  typedef struct packed {
    logic sleep_instr;
    logic clear_watchdog_instr;
    logic osc_fail;
    logic ost_running;
    logic crystal_clock;
    logic lf_osc_selected;
  } wds_core_s;

  // wake sources: timer1 async, capture, rc conversion, nv write, comparator,
  // pin change, external pin
  typedef struct packed {
    logic [6:0] flags;
    logic [6:0] enables;
    logic global_irq_enable;
  } wds_wake_s;

  // one-cycle pulses back to the core
  typedef struct packed {
    logic prefetch_next;
    logic resume;
    logic branch_vector;
    logic sleep_nop;
  } wds_resume_s;

  typedef struct packed {
    wds_mode_e mode;
    logic [3:0] period_select;
    logic soft_watchdog_enable;
    logic [7:0] pin_setup;
    logic [7:0] setup_word;
    logic timeout_flag;
    logic powerdown_flag;
    logic ost_hold;
    logic ost_seen;
    logic low_osc_running_flag;
    logic lf_osc_enable;
    logic osc_driver_off;
    logic io_hold;
    logic wdt_reset;
    logic master_clear_pin_drive_low;
    wds_resume_s resume;
    logic wb_ack;
    logic [31:0] wb_dat;
  } wds_state_s;

endpackage : wds_pkg

// ===== logic/wds_div_counter.sv
`timescale 1ns/1ns
// counts enabled cycles up to a limit and pulses once when it wraps
module wds_div_counter #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [W-1:0] limit_i,
  // terminal pulse
  output logic tick_o
);

  typedef struct packed {
    logic [W-1:0] count;
    logic tick;
  } wds_cnt_s;

  wds_cnt_s st;
  wds_cnt_s next_st;

  // clear beats enable so a restart never leaks a stale tick
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clr_i)
    begin
      next_st.count = '0;
    end
    else if (en_i)
    begin
      if (st.count >= limit_i)
      begin
        next_st.count = '0;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.count = W'(st.count + 1'b1);
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule : wds_div_counter

// ===== logic/wds_watchdog.sv
`timescale 1ns/1ns
module wds_watchdog
  import wds_pkg::*;
#(
  parameter int unsigned LF_TICK_CYC = wds_pkg::WDS_LF_TICK_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire wds_pkg::wds_wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core and clock unit
  input wire wds_pkg::wds_core_s core_i,
  input wire wds_pkg::wds_wake_s wake_i,
  output wds_pkg::wds_resume_s resume_o,
  // reset and power control
  output logic wdt_reset_o,
  output logic master_clear_pin_drive_low_o,
  output logic osc_driver_off_o,
  output logic io_hold_o,
  output logic lf_osc_enable_o,
  output logic low_osc_running_flag_o,
  // status flags
  output logic timeout_flag_o,
  output logic powerdown_flag_o
);

  import wds_pkg::*;

  wds_state_s st;
  wds_state_s next_st;
  logic lf_tick;
  logic pre_tick;
  logic post_tick;
  logic wdt_en;
  logic wdt_run;
  logic wdt_clear;
  logic irq_pending;
  logic sleep_exec;
  logic sleep_nop;
  logic timeout_raw;
  logic prescaler_assign;
  logic [2:0] rate;
  logic [15:0] pre_limit;
  logic [7:0] post_limit;
  logic wb_req;

  // ratio 32 << code, reserved codes held at the longest ratio
  function automatic logic [15:0] wds_pre_limit(input logic [3:0] code);
    logic [31:0] ratio;
    ratio = 32'(WDS_BASE_RATIO) << ((code > WDS_PERIOD_MAX) ? WDS_PERIOD_MAX : code);
    return 16'(ratio - 32'd1);
  endfunction : wds_pre_limit

  // enables, clears and wake conditions
  always_comb
  begin
    prescaler_assign = st.pin_setup[WDS_OPT_ASSIGN_BIT];
    rate = st.pin_setup[WDS_OPT_RATE_LSB +: 3];
    pre_limit = wds_pre_limit(st.period_select);
    post_limit = 8'((9'h001 << rate) - 9'h001);
    wdt_en = st.setup_word[WDS_CFG_FIXED_EN_BIT] | st.soft_watchdog_enable;
    wdt_run = wdt_en & ~core_i.ost_running & ~st.ost_hold;
    irq_pending = |(wake_i.flags & wake_i.enables);
    sleep_exec = core_i.sleep_instr & (st.mode == WDS_AWAKE) & ~irq_pending;
    sleep_nop = core_i.sleep_instr & (st.mode == WDS_AWAKE) & irq_pending;
    timeout_raw = wdt_run & (prescaler_assign ? post_tick : pre_tick)
      & ~core_i.clear_watchdog_instr & ~core_i.osc_fail & ~sleep_exec;
    // any wake or sleep entry restarts the count from zero
    wdt_clear = ~wdt_run | core_i.clear_watchdog_instr | core_i.osc_fail
      | sleep_exec
      | ((st.mode == WDS_SLEEP) & (irq_pending | timeout_raw));
    wb_req = wb_i.cyc & wb_i.stb & ~st.wb_ack;
  end

  // free-running low-frequency tick; it belongs to the oscillator, not the watchdog
  wds_div_counter #(
    .W(14)
  ) u_lf_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(1'b0),
    .en_i(1'b1),
    .limit_i(14'(LF_TICK_CYC - 1)),
    .tick_o(lf_tick)
  );

  // 16-bit period prescaler
  wds_div_counter #(
    .W(16)
  ) u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(wdt_clear),
    .en_i(lf_tick),
    .limit_i(pre_limit),
    .tick_o(pre_tick)
  );

  // shared 8-bit prescaler, used only when assigned to the watchdog
  wds_div_counter #(
    .W(8)
  ) u_postscale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(wdt_clear | ~prescaler_assign),
    .en_i(pre_tick),
    .limit_i(post_limit),
    .tick_o(post_tick)
  );

  // next state: sleep control, flags and register slave
  always_comb
  begin
    next_st = st;
    next_st.wdt_reset = 1'b0;
    next_st.resume = '0;
    next_st.wb_ack = 1'b0;
    next_st.wb_dat = '0;
    next_st.master_clear_pin_drive_low = 1'b0;
    // flag follows the clock selection only, so a watchdog-only request stays hidden
    next_st.low_osc_running_flag = core_i.lf_osc_selected;
    next_st.lf_osc_enable = core_i.lf_osc_selected | wdt_en;
    // start-up hold after a crystal wake: release once the timer has run and stopped
    if (st.ost_hold)
    begin
      if (core_i.ost_running)
      begin
        next_st.ost_seen = 1'b1;
      end
      else if (st.ost_seen)
      begin
        next_st.ost_hold = 1'b0;
        next_st.ost_seen = 1'b0;
      end
    end
    case (st.mode)
      WDS_AWAKE:
      begin
        if (sleep_exec)
        begin
          next_st.mode = WDS_SLEEP;
          next_st.powerdown_flag = 1'b0;
          next_st.timeout_flag = 1'b1;
          next_st.osc_driver_off = 1'b1;
          next_st.io_hold = 1'b1;
          next_st.resume.prefetch_next = 1'b1;
        end
        else if (sleep_nop)
        begin
          next_st.resume.sleep_nop = 1'b1;
        end
        else if (timeout_raw)
        begin
          next_st.wdt_reset = 1'b1;
          next_st.timeout_flag = 1'b0;
        end
      end
      WDS_SLEEP:
      begin
        if (irq_pending | timeout_raw)
        begin
          next_st.mode = WDS_WAKE;
          next_st.resume.resume = 1'b1;
          next_st.resume.branch_vector = irq_pending & wake_i.global_irq_enable;
          next_st.osc_driver_off = 1'b0;
          next_st.io_hold = 1'b0;
          next_st.ost_hold = core_i.crystal_clock;
          next_st.ost_seen = 1'b0;
          if (timeout_raw)
          begin
            next_st.timeout_flag = 1'b0;
          end
        end
      end
      WDS_WAKE:
      begin
        next_st.mode = WDS_AWAKE;
      end
      default:
      begin
        next_st.mode = WDS_AWAKE;
      end
    endcase
    // register slave answers every request one cycle later, unmapped reads give zero
    if (wb_req)
    begin
      next_st.wb_ack = 1'b1;
      if (wb_i.we && wb_i.sel[0])
      begin
        if (wb_i.adr == WDS_ADDR_CTRL)
        begin
          next_st.period_select = wb_i.dat[WDS_CTRL_PERIOD_LSB +: 4];
          next_st.soft_watchdog_enable = wb_i.dat[WDS_CTRL_SOFT_EN_BIT];
        end
        else if (wb_i.adr == WDS_ADDR_PIN_SETUP)
        begin
          next_st.pin_setup = wb_i.dat[7:0];
        end
        else if (wb_i.adr == WDS_ADDR_SETUP_WORD)
        begin
          next_st.setup_word = wb_i.dat[7:0];
        end
      end
      else if (!wb_i.we)
      begin
        if (wb_i.adr == WDS_ADDR_CTRL)
        begin
          next_st.wb_dat = {27'h0000000, st.period_select, st.soft_watchdog_enable};
        end
        else if (wb_i.adr == WDS_ADDR_PIN_SETUP)
        begin
          next_st.wb_dat = {24'h000000, st.pin_setup};
        end
        else if (wb_i.adr == WDS_ADDR_SETUP_WORD)
        begin
          next_st.wb_dat = {24'h000000, st.setup_word};
        end
        else if (wb_i.adr == WDS_ADDR_STATUS)
        begin
          next_st.wb_dat = {26'h0000000, wdt_run, st.mode == WDS_SLEEP, st.ost_hold,
            st.low_osc_running_flag, st.timeout_flag, st.powerdown_flag};
        end
      end
    end
  end

  // state register; every reset reloads the control defaults
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.mode <= WDS_AWAKE;
      st.period_select <= WDS_PERIOD_RST;
      st.soft_watchdog_enable <= WDS_SOFT_EN_RST;
      st.pin_setup <= WDS_PIN_SETUP_RST;
      st.setup_word <= WDS_SETUP_WORD_RST;
      st.timeout_flag <= 1'b1;
      st.powerdown_flag <= 1'b1;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = st.wb_dat;
  assign wb_ack_o = st.wb_ack;
  assign resume_o = st.resume;
  assign wdt_reset_o = st.wdt_reset;
  assign master_clear_pin_drive_low_o = st.master_clear_pin_drive_low;
  assign osc_driver_off_o = st.osc_driver_off;
  assign io_hold_o = st.io_hold;
  assign lf_osc_enable_o = st.lf_osc_enable;
  assign low_osc_running_flag_o = st.low_osc_running_flag;
  assign timeout_flag_o = st.timeout_flag;
  assign powerdown_flag_o = st.powerdown_flag;

  default clocking wds_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_CTRL_RESET: assert property ($past(rst_i) |-> st.period_select == 4'h4
    && !st.soft_watchdog_enable)
    else $error("control register not at reset value after reset");
  AST_RSV_ZERO: assert property (wb_ack_o && $past(wb_i.adr) == WDS_ADDR_CTRL
    && !$past(wb_i.we) |-> wb_dat_o[7:5] == 3'h0)
    else $error("control bits 7-5 read nonzero");
  AST_FIXED_EN: assert property (st.setup_word[3] && !core_i.ost_running
    && !st.ost_hold |-> wdt_run)
    else $error("fixed enable did not run the watchdog");
  AST_SOFT_OFF: assert property (!st.setup_word[3] && !st.soft_watchdog_enable
    |-> !wdt_run && wdt_clear)
    else $error("watchdog runs while disabled");
  AST_OST_HOLD: assert property (core_i.ost_running |-> !wdt_run && wdt_clear)
    else $error("watchdog counted during oscillator start-up");
  AST_SLEEP_ENTRY: assert property (ce_i && sleep_exec ##1 ce_i |-> st.mode == WDS_SLEEP
    && !powerdown_flag_o && timeout_flag_o && io_hold_o && resume_o.prefetch_next)
    else $error("sleep entry effects missing");
  AST_SLEEP_NOP: assert property (ce_i && sleep_nop |=> st.mode == WDS_AWAKE
    && $stable(powerdown_flag_o) && $stable(timeout_flag_o) && resume_o.sleep_nop)
    else $error("sleep with pending interrupt was not a no-op");
  AST_IRQ_WAKE: assert property (ce_i && st.mode == WDS_SLEEP && irq_pending
    |=> resume_o.resume ##1 st.mode == WDS_AWAKE)
    else $error("enabled interrupt did not wake the device");
  AST_VECTOR: assert property (resume_o.branch_vector |-> resume_o.resume
    && $past(wake_i.global_irq_enable) && $past(irq_pending))
    else $error("vector branch without an enabled interrupt wake");
  AST_WDT_WAKE: assert property (ce_i && st.mode == WDS_SLEEP && timeout_raw
    |=> !timeout_flag_o && resume_o.resume && !wdt_reset_o)
    else $error("watchdog wake did not clear the timeout flag");
  AST_WDT_RESET: assert property (wdt_reset_o |-> !timeout_flag_o && !master_clear_pin_drive_low_o
    && $past(st.mode) == WDS_AWAKE)
    else $error("watchdog reset signalled wrongly");

endmodule : wds_watchdog

// ===== sim/wds_core_model.sv
`timescale 1ns/1ns
// processor core stand-in: turns bench commands into instruction pulses
module wds_core_model
  import wds_pkg::*;
#(
  parameter int OST_CYC = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench commands
  input wire logic sleep_cmd_i,
  input wire logic clear_cmd_i,
  input wire logic fail_i,
  input wire logic ost_cmd_i,
  input wire logic crystal_i,
  input wire logic lf_sel_i,
  // block feedback
  input wire logic io_hold_i,
  input wire logic resume_i,
  // to the block
  output wds_pkg::wds_core_s core_o
);
  int ost_left;

  // a sleeping core executes nothing, so its instruction pulses are gated
  always_comb
  begin
    core_o.sleep_instr = sleep_cmd_i && !io_hold_i;
    core_o.clear_watchdog_instr = clear_cmd_i && !io_hold_i;
    core_o.osc_fail = fail_i;
    core_o.ost_running = ost_cmd_i || (ost_left != 0);
    core_o.crystal_clock = crystal_i;
    core_o.lf_osc_selected = lf_sel_i;
  end

  // a crystal must restart after wake, so the start-up timer runs a while
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ost_left <= 0;
    else if (resume_i && crystal_i)
      ost_left <= OST_CYC;
    else if (ost_left != 0)
      ost_left <= ost_left - 1;
  end
endmodule : wds_core_model

// ===== sim/test_wds_watchdog.sv
`timescale 1ns/1ns
module test_wds_watchdog;
  import wds_pkg::*;
  localparam int LF = 4;
  localparam logic [7:0] T_CTRL [5] = '{8'h01, 8'h03, 8'h05, 8'h00, 8'h01};
  localparam logic [7:0] T_OPT [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h09};
  localparam logic [7:0] T_CFG [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wds_wb_req_s wb_i = '0;
  wds_wake_s wake_i = '0;
  logic sleep_cmd = 1'b0;
  logic clear_cmd = 1'b0;
  logic fail = 1'b0;
  logic ost_cmd = 1'b0;
  logic crystal = 1'b0;
  logic ce = 1'b1;
  logic lf_sel = 1'b0;
  wds_core_s core_i;
  wds_resume_s resume_o;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wdt_reset_o, master_clear_pin_drive_low_o, osc_driver_off_o, io_hold_o;
  logic lf_osc_enable_o, low_osc_running_flag_o, timeout_flag_o, powerdown_flag_o;
  int fails = 0;
  int checks = 0;
  int n;
  int exp;
  logic [15:0] rd_q[$];
  logic [4:0] ev_q[$];
  logic [15:0] e;
  logic [4:0] ev;
  logic [7:0] r;

  // 250 MHz clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  wds_watchdog #(.LF_TICK_CYC(LF)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_i(core_i), .wake_i(wake_i), .resume_o(resume_o),
    .wdt_reset_o(wdt_reset_o), .master_clear_pin_drive_low_o(master_clear_pin_drive_low_o),
    .osc_driver_off_o(osc_driver_off_o), .io_hold_o(io_hold_o),
    .lf_osc_enable_o(lf_osc_enable_o), .low_osc_running_flag_o(low_osc_running_flag_o),
    .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o));

  wds_core_model MODEL (
    .clk_i(clk_i), .rst_i(rst_i), .sleep_cmd_i(sleep_cmd), .clear_cmd_i(clear_cmd),
    .fail_i(fail), .ost_cmd_i(ost_cmd), .crystal_i(crystal), .lf_sel_i(lf_sel),
    .io_hold_i(io_hold_o), .resume_i(resume_o.resume), .core_o(core_i));

  task automatic final_report();
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic note(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : note

  // one wrapper per kind of result
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] want);
    note(got, want);
  endtask : cmp_rd

  task automatic cmp_ev(input logic [4:0] got, input logic [4:0] want);
    note({3'h0, got}, {3'h0, want});
  endtask : cmp_ev

  task automatic cmp_flag(input logic got, input logic want);
    note({7'h0, got}, {7'h0, want});
  endtask : cmp_flag

  task automatic give_up();
    fails++;
    final_report();
  endtask : give_up

  // classic cycle: request held until ack is sampled, then released for a cycle
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: {24'h0, d}};
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    wb_i <= '0;
    if (k == 50)
      give_up();
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [7:0] mask, input logic [7:0] want);
    rd_q.push_back({mask, want});
    bus(1'b0, adr, 8'h00);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask : idle

  task automatic wait_ev(input int lim);
    for (int k = 0; k < lim && ev_q.size() != 0; k++)
      @(posedge clk_i);
    if (ev_q.size() != 0)
      give_up();
  endtask : wait_ev

  task automatic do_sleep();
    @(posedge clk_i);
    sleep_cmd <= 1'b1;
    @(posedge clk_i);
    sleep_cmd <= 1'b0;
  endtask : do_sleep

  // cycles up to the next awake time-out pulse
  task automatic gap(output int c);
    ev_q.push_back(5'h01);
    for (c = 0; c < 3000; c++)
    begin
      @(negedge clk_i);
      if (wdt_reset_o === 1'b1)
        break;
    end
    // a missing pulse is a mismatch, not a silent short measurement
    if (c == 3000)
      give_up();
  endtask : gap

  // watcher: settled outputs at the falling edge; any unexpected pulse fails
  always @(negedge clk_i)
  begin
    if (!rst_i && wb_ack_o === 1'b1 && wb_i.we === 1'b0)
    begin
      e = rd_q.pop_front();
      cmp_rd(wb_dat_o[7:0] & e[15:8], e[7:0]);
    end
    ev = {resume_o.prefetch_next, resume_o.resume, resume_o.branch_vector,
      resume_o.sleep_nop, wdt_reset_o};
    if (!rst_i && ev !== 5'h00)
      cmp_ev(ev, (ev_q.size() != 0) ? ev_q.pop_front() : 5'h00);
  end

  initial
  begin
    r = $urandom(20156);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped read
    rd(WDS_ADDR_CTRL, 8'hff, 8'h08);
    rd(WDS_ADDR_PIN_SETUP, 8'hff, 8'hff);
    rd(WDS_ADDR_SETUP_WORD, 8'hff, WDS_SETUP_WORD_RST);
    rd(WDS_ADDR_STATUS, 8'h13, 8'h03);
    rd(8'h10, 8'hff, 8'h00);
    // pending enabled interrupt turns sleep into a no-op
    wake_i <= '{flags: 7'h01, enables: 7'h01, global_irq_enable: 1'b0};
    ev_q.push_back(5'h02);
    do_sleep();
    wait_ev(10);
    rd(WDS_ADDR_STATUS, 8'h13, 8'h03);
    cmp_flag(powerdown_flag_o, 1'b1);
    wake_i <= '0;
    // top bits never stored
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      wr(WDS_ADDR_CTRL, {r[7:1], 1'b0});
      rd(WDS_ADDR_CTRL, 8'hff, {3'h0, r[4:1], 1'b0});
    end
    // a reset in mid-run reloads the control defaults over the random values
    rst_i <= 1'b1;
    idle(1);
    rst_i <= 1'b0;
    rd(WDS_ADDR_CTRL, 8'hff, 8'h08);
    rd(WDS_ADDR_PIN_SETUP, 8'hff, 8'hff);
    // time-out period for each setting, measured between two pulses
    for (int i = 0; i < 5; i++)
    begin
      wr(WDS_ADDR_PIN_SETUP, T_OPT[i]);
      wr(WDS_ADDR_SETUP_WORD, T_CFG[i]);
      wr(WDS_ADDR_CTRL, T_CTRL[i]);
      gap(n);
      gap(n);
      exp = ((32 << T_CTRL[i][4:1]) * LF) << (T_OPT[i][3] ? int'(T_OPT[i][2:0]) : 0);
      cmp_flag(n >= exp - 4 && n <= exp + 8, 1'b1);
      cmp_flag(low_osc_running_flag_o, 1'b0);
      cmp_flag(lf_osc_enable_o, 1'b1);
      cmp_flag(master_clear_pin_drive_low_o, 1'b0);
      rd(WDS_ADDR_STATUS, 8'h02, 8'h00);
      wr(WDS_ADDR_SETUP_WORD, 8'h00);
      wr(WDS_ADDR_CTRL, 8'h00);
    end
    // start-up timer, clear pulses and oscillator failure keep the count low
    ost_cmd <= 1'b1;
    wr(WDS_ADDR_CTRL, 8'h01);
    idle(400);
    ost_cmd <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      idle(100);
      clear_cmd <= 1'b1;
      idle(1);
      clear_cmd <= 1'b0;
    end
    // a low clock enable freezes the count, so a pause longer than the period is quiet
    ce <= 1'b0;
    idle(300);
    ce <= 1'b1;
    fail <= 1'b1;
    idle(300);
    fail <= 1'b0;
    wr(WDS_ADDR_CTRL, 8'h00);
    // every wake source, unenabled first, random global enable
    for (int i = 0; i < 7; i++)
    begin
      r = $urandom;
      crystal <= r[1];
      ev_q.push_back(5'h10);
      do_sleep();
      wait_ev(10);
      rd(WDS_ADDR_STATUS, 8'h13, 8'h12);
      cmp_flag(io_hold_o & osc_driver_off_o, 1'b1);
      wake_i <= '{flags: 7'(1 << i), enables: 7'h00, global_irq_enable: r[0]};
      idle(20);
      ev_q.push_back({2'b01, r[0], 2'b00});
      wake_i.enables <= 7'(1 << i);
      wait_ev(10);
      wake_i <= '0;
      rd(WDS_ADDR_STATUS, 8'h13, 8'h02);
      idle(10);
    end
    // time-out asleep wakes and continues
    wr(WDS_ADDR_CTRL, 8'h01);
    ev_q.push_back(5'h10);
    ev_q.push_back(5'h08);
    do_sleep();
    wait_ev(400);
    rd(WDS_ADDR_STATUS, 8'h13, 8'h00);
    wr(WDS_ADDR_CTRL, 8'h00);
    // oscillator chosen as system clock, watchdog off: flag and enable follow the selection
    lf_sel <= 1'b1;
    idle(2);
    @(negedge clk_i);
    cmp_flag(low_osc_running_flag_o, 1'b1);
    cmp_flag(lf_osc_enable_o, 1'b1);
    idle(1);
    lf_sel <= 1'b0;
    idle(2);
    @(negedge clk_i);
    cmp_flag(low_osc_running_flag_o, 1'b0);
    cmp_flag(lf_osc_enable_o, 1'b0);
    final_report();
  end
endmodule : test_wds_watchdog
